// File: design/pts_pkg.sv
package pts_pkg;
    localparam int PTS_IDX_W = 8;
    localparam int PTS_POS_W = 32;
    localparam int PTS_SPD_W = 16;
    localparam int PTS_ACC_W = 16;
    localparam int PTS_DWL_W = 16;
    localparam int PTS_AUX_W = 4;
    localparam int PTS_MC_W = 8;
    localparam int PTS_ENTRY_W = PTS_POS_W + PTS_SPD_W + 2 * PTS_ACC_W + PTS_DWL_W + PTS_AUX_W
        + PTS_MC_W;
    localparam int PTS_DEPTH = 256;
    // Entry field positions, low to high
    localparam int PTS_F_POS = 0;
    localparam int PTS_F_SPD = PTS_F_POS + PTS_POS_W;
    localparam int PTS_F_ACC = PTS_F_SPD + PTS_SPD_W;
    localparam int PTS_F_DEC = PTS_F_ACC + PTS_ACC_W;
    localparam int PTS_F_DWL = PTS_F_DEC + PTS_ACC_W;
    localparam int PTS_F_AUX = PTS_F_DWL + PTS_DWL_W;
    localparam int PTS_F_MC = PTS_F_AUX + PTS_AUX_W;
    // Auxiliary codes
    localparam logic [3:0] PTS_AUX_ABS_END = 4'h0;
    localparam logic [3:0] PTS_AUX_ABS_CONT = 4'h1;
    localparam logic [3:0] PTS_AUX_REL_END = 4'h2;
    localparam logic [3:0] PTS_AUX_REL_CONT = 4'h3;
    localparam logic [3:0] PTS_AUX_ABS_RPT_START = 4'h8;
    localparam logic [3:0] PTS_AUX_ABS_RPT_ONE = 4'h9;
    localparam logic [3:0] PTS_AUX_REL_RPT_START = 4'hA;
    localparam logic [3:0] PTS_AUX_REL_RPT_ONE = 4'hB;
    localparam logic [7:0] PTS_FIRST_ENTRY = 8'h01;
    localparam logic [7:0] PTS_LAST_CHAIN = 8'hFE;
    localparam int PTS_CTRL_NEW_SETPOINT = 4;
    // Wishbone map
    localparam logic [7:0] PTS_A_CTRL = 8'h00;
    localparam logic [7:0] PTS_A_START = 8'h04;
    localparam logic [7:0] PTS_A_INP_RANGE = 8'h08;
    localparam logic [7:0] PTS_A_CRP_RANGE = 8'h0C;
    localparam logic [7:0] PTS_A_STATUS = 8'h10;
    localparam logic [7:0] PTS_A_CUR = 8'h14;
    localparam logic [7:0] PTS_A_TBL_IDX = 8'h18;
    localparam logic [7:0] PTS_A_TBL_DATA = 8'h20;
    localparam int PTS_TBL_WORDS = 5;
    localparam logic [31:0] PTS_INP_RANGE_RST = 32'h0000_0064;
    localparam logic [31:0] PTS_CRP_RANGE_RST = 32'h0000_0000;
    // Status bit positions
    localparam int PTS_IN_POSITION_FLAG = 0;
    localparam int PTS_ROUGH_MATCH_FLAG = 1;
    localparam int PTS_TRAVEL_COMPLETE_FLAG = 2;
    localparam int PTS_S_BUSY = 3;
    localparam int PTS_S_REL = 4;
    localparam int PTS_S_SERVO = 5;
    localparam int PTS_S_STOP = 6;
    // Dwell timebase: 1 ms at 40 MHz
    localparam int PTS_CLK_HZ = 40_000_000;
    localparam int PTS_DWELL_UNIT_US = 1000;
    localparam int PTS_MS_CYCLES = PTS_CLK_HZ / 1_000_000 * PTS_DWELL_UNIT_US;
endpackage : pts_pkg

// File: design/pts_table_mem.sv
`timescale 1ns/1ps
module pts_table_mem #(
    parameter int WIDTH = 128,
    parameter int DEPTH = 256,
    parameter int AW = 8
) (
    // Clock
    input wire logic clk,
    // Write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    // Registered read port
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule : pts_table_mem

// File: design/pts_sequencer.sv
// The Wishbone interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - Aux 1 or 3: switch to next entry speed mid-move, no stop.
// - Next entry acceleration and deceleration applied together with its speed.
// - Chains may run to entry 255, i.e. 255 speed steps.
// - Aux 0 means absolute target, aux 2 relative target.
// - Continuation code runs consecutive entries as continuous positioning.
// - In-position when droop is at or below in-position range.
// - Rough match when remaining distance within range; off while continuous.
// - Travel complete needs in-position and zero remaining; off while continuous.
// - Aux 8 or 10 restart from starting entry after completion.
// - Aux 9 or 11 restart from entry 1 after completion.
// - Aux 1 absolute, aux 3 relative, both continue to next.
// - Start only servo on and stopped; ignore trigger while rotating.
// - Reported entry and output code hold until operation completes.
module pts_sequencer
    import pts_pkg::*;
#(
    parameter int DWELL_MS_CYCLES = PTS_MS_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Drive status inputs
    input wire logic servo_on,
    input wire logic motor_stopped,
    input wire logic [PTS_POS_W-1:0] droop,
    input wire logic [PTS_POS_W-1:0] remaining,
    // Motion profile generator handshake
    input wire logic seg_near_end,
    input wire logic seg_done,
    output logic seg_load,
    output logic [PTS_POS_W-1:0] seg_target,
    output logic seg_relative,
    output logic seg_blend,
    output logic [PTS_SPD_W-1:0] seg_speed,
    output logic [PTS_ACC_W-1:0] seg_acc,
    output logic [PTS_ACC_W-1:0] seg_dec,
    // Status flags, reported entry and output code
    output logic in_position_flag,
    output logic rough_match_flag,
    output logic travel_complete_flag,
    output logic [PTS_IDX_W-1:0] point_actual,
    output logic [PTS_MC_W-1:0] mcode_actual
);
    typedef enum logic [5:0] {
        PTS_IDLE = 6'b00_0001,
        PTS_FETCH = 6'b00_0010,
        PTS_ISSUE = 6'b00_0100,
        PTS_RUN = 6'b00_1000,
        PTS_DWELL = 6'b01_0000,
        PTS_WAIT = 6'b10_0000
    } pts_state_t;

    pts_state_t state_r, state_nxt;
    logic [PTS_IDX_W-1:0] idx_r, start_idx_r, tbl_idx_r, start_sel_r;
    logic [PTS_IDX_W-1:0] cur_idx_r;
    logic [31:0] inp_range_r, crp_range_r;
    logic [PTS_ENTRY_W-1:0] stage_r;
    logic [PTS_ENTRY_W-1:0] cur_r;
    logic ctrl_nsp_r, nsp_prev_r, chain_r, ack_r;
    logic [15:0] dwell_ms_r;
    logic [31:0] dwell_cyc_r;
    logic [PTS_ENTRY_W-1:0] rd_data;
    logic preload_r;

    // Bus decode
    wire bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
    // Writes land on the edge where the master sees ack high
    wire bus_wr = wb_cyc_i & wb_stb_i & ack_r & wb_we_i & (&wb_sel_i);
    wire wr_ctrl = bus_wr & (wb_adr_i == PTS_A_CTRL);
    wire wr_start = bus_wr & (wb_adr_i == PTS_A_START);
    wire wr_inp = bus_wr & (wb_adr_i == PTS_A_INP_RANGE);
    wire wr_crp = bus_wr & (wb_adr_i == PTS_A_CRP_RANGE);
    wire wr_tidx = bus_wr & (wb_adr_i == PTS_A_TBL_IDX);
    wire [7:0] data_off = wb_adr_i - PTS_A_TBL_DATA;
    wire in_tbl = (wb_adr_i >= PTS_A_TBL_DATA) && (data_off[7:2] < 6'(PTS_TBL_WORDS));
    wire wr_word = bus_wr & in_tbl;
    wire [2:0] word_sel = data_off[4:2];
    wire last_word = word_sel == 3'(PTS_TBL_WORDS - 1);
    wire mem_wr = wr_word & last_word;

    logic [PTS_TBL_WORDS*32-1:0] wbuf_r;
    wire [PTS_TBL_WORDS*32-1:0] wbuf_nxt = (wbuf_r & ~({{(PTS_TBL_WORDS*32-32){1'b0}}, 32'hFFFF_FFFF}
        << (word_sel * 32))) | ({{(PTS_TBL_WORDS*32-32){1'b0}}, wb_dat_i} << (word_sel * 32));

    // Status and trigger
    wire nsp_rise = ctrl_nsp_r & ~nsp_prev_r;
    wire start_ok = nsp_rise & servo_on & motor_stopped & (state_r == PTS_IDLE);
    wire [3:0] cur_aux = cur_r[PTS_F_AUX +: PTS_AUX_W];
    wire [3:0] stg_aux = stage_r[PTS_F_AUX +: PTS_AUX_W];
    wire cur_cont = (cur_aux == PTS_AUX_ABS_CONT) | (cur_aux == PTS_AUX_REL_CONT);
    wire cur_rpt_start = (cur_aux == PTS_AUX_ABS_RPT_START) | (cur_aux == PTS_AUX_REL_RPT_START);
    wire cur_rpt_one = (cur_aux == PTS_AUX_ABS_RPT_ONE) | (cur_aux == PTS_AUX_REL_RPT_ONE);
    // Chain may continue through entry 254 into 255
    wire can_next = cur_cont & (idx_r <= PTS_LAST_CHAIN);
    wire [PTS_IDX_W-1:0] next_idx = cur_rpt_start ? start_idx_r
        : cur_rpt_one ? PTS_FIRST_ENTRY : idx_r + 8'h01;
    wire [15:0] cur_dwell = cur_r[PTS_F_DWL +: PTS_DWL_W];
    wire dwell_zero = cur_dwell == 16'h0000;
    wire rpt = cur_rpt_start | cur_rpt_one;
    wire rd_aux_rel = (stg_aux == PTS_AUX_REL_END) | (stg_aux == PTS_AUX_REL_CONT)
        | (stg_aux == PTS_AUX_REL_RPT_START) | (stg_aux == PTS_AUX_REL_RPT_ONE);
    wire [PTS_IDX_W-1:0] mem_rd_addr = (state_r == PTS_IDLE) ? start_sel_r : next_idx;

    pts_table_mem #(
        .WIDTH(PTS_ENTRY_W),
        .DEPTH(PTS_DEPTH),
        .AW(PTS_IDX_W)
    ) u_mem (
        .clk(clk),
        .wr_en(mem_wr),
        .wr_addr(tbl_idx_r),
        .wr_data(wbuf_nxt[PTS_ENTRY_W-1:0]),
        .rd_addr(mem_rd_addr),
        .rd_data(rd_data)
    );

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            PTS_IDLE:
                if (start_ok)
                begin
                    state_nxt = PTS_FETCH;
                end
            PTS_FETCH:
                state_nxt = PTS_ISSUE;
            PTS_ISSUE:
                state_nxt = PTS_RUN;
            PTS_RUN:
                if (!servo_on)
                begin
                    state_nxt = PTS_IDLE;
                end
                // Blend into next entry on continuation
                else if (can_next && seg_near_end && preload_r)
                begin
                    state_nxt = PTS_ISSUE;
                end
                else if (seg_done)
                begin
                    state_nxt = (rpt && !dwell_zero) ? PTS_DWELL
                        : rpt ? PTS_WAIT : PTS_IDLE;
                end
            PTS_DWELL:
                if (dwell_ms_r == cur_dwell)
                begin
                    state_nxt = PTS_WAIT;
                end
            PTS_WAIT:
                state_nxt = PTS_ISSUE;
            default:
                state_nxt = PTS_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            state_r <= PTS_IDLE;
            ack_r <= 1'b0;
            ctrl_nsp_r <= 1'b0;
            nsp_prev_r <= 1'b0;
            start_sel_r <= PTS_FIRST_ENTRY;
            tbl_idx_r <= 8'h00;
            inp_range_r <= PTS_INP_RANGE_RST;
            crp_range_r <= PTS_CRP_RANGE_RST;
            wbuf_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            ack_r <= bus_req;
            nsp_prev_r <= ctrl_nsp_r;
            if (wr_ctrl)
            begin
                ctrl_nsp_r <= wb_dat_i[PTS_CTRL_NEW_SETPOINT];
            end
            if (wr_start)
            begin
                start_sel_r <= wb_dat_i[PTS_IDX_W-1:0];
            end
            if (wr_inp)
            begin
                inp_range_r <= wb_dat_i;
            end
            if (wr_crp)
            begin
                crp_range_r <= wb_dat_i;
            end
            if (wr_tidx)
            begin
                tbl_idx_r <= wb_dat_i[PTS_IDX_W-1:0];
            end
            if (wr_word)
            begin
                wbuf_r <= wbuf_nxt;
            end
        end
    end

    // Sequencing datapath
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            idx_r <= 8'h00;
            start_idx_r <= 8'h00;
            cur_idx_r <= 8'h00;
            stage_r <= '0;
            cur_r <= '0;
            chain_r <= 1'b0;
            preload_r <= 1'b0;
            dwell_ms_r <= 16'h0000;
            dwell_cyc_r <= 32'h0000_0000;
            seg_load <= 1'b0;
            seg_target <= '0;
            seg_relative <= 1'b0;
            seg_blend <= 1'b0;
            seg_speed <= '0;
            seg_acc <= '0;
            seg_dec <= '0;
            point_actual <= 8'h00;
            mcode_actual <= 8'h00;
        end
        else
        begin
            seg_load <= 1'b0;
            if (start_ok)
            begin
                start_idx_r <= start_sel_r;
                idx_r <= start_sel_r;
                chain_r <= 1'b0;
                // Stale code from a past run would misaim the first preload
                cur_r <= '0;
            end
            if (state_r == PTS_FETCH)
            begin
                stage_r <= rd_data;
            end
            if (state_r == PTS_ISSUE)
            begin
                // Speed and ramps taken from the new entry together
                seg_speed <= stage_r[PTS_F_SPD +: PTS_SPD_W];
                seg_acc <= stage_r[PTS_F_ACC +: PTS_ACC_W];
                seg_dec <= stage_r[PTS_F_DEC +: PTS_ACC_W];
                seg_target <= stage_r[PTS_F_POS +: PTS_POS_W];
                // Absolute or relative target by code
                seg_relative <= rd_aux_rel;
                // Blend only when following a continuation, not after a restart
                seg_blend <= chain_r & cur_cont;
                seg_load <= 1'b1;
                cur_r <= stage_r;
                cur_idx_r <= idx_r;
                preload_r <= 1'b0;
            end
            // Preload next entry while the segment runs
            if (state_r == PTS_RUN && !preload_r)
            begin
                preload_r <= 1'b1;
                stage_r <= rd_data;
            end
            if (state_r == PTS_RUN && state_nxt == PTS_ISSUE)
            begin
                idx_r <= idx_r + 8'h01;
                chain_r <= 1'b1;
            end
            if (state_r == PTS_RUN && state_nxt != PTS_RUN && state_nxt != PTS_ISSUE)
            begin
                // Report only once the operation completes
                if (seg_done)
                begin
                    point_actual <= cur_idx_r;
                    mcode_actual <= cur_r[PTS_F_MC +: PTS_MC_W];
                end
                chain_r <= rpt;
                dwell_ms_r <= 16'h0000;
                dwell_cyc_r <= 32'h0000_0000;
            end
            if (state_r == PTS_DWELL)
            begin
                if (dwell_cyc_r == 32'(DWELL_MS_CYCLES - 1))
                begin
                    dwell_cyc_r <= 32'h0000_0000;
                    dwell_ms_r <= dwell_ms_r + 16'h0001;
                end
                else
                begin
                    dwell_cyc_r <= dwell_cyc_r + 32'h0000_0001;
                end
            end
            if (state_r == PTS_WAIT)
            begin
                // Restart point; read data was addressed by next_idx
                idx_r <= next_idx;
                stage_r <= rd_data;
                // Cleared so the following preload reads the entry after the restart
                cur_r <= '0;
            end
        end
    end

    // Flags are registered one cycle behind live droop and remaining distance
    wire seq_running = (state_r != PTS_IDLE) & (chain_r | can_next | rpt);
    wire inp_now = droop <= inp_range_r;
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            in_position_flag <= 1'b0;
            rough_match_flag <= 1'b0;
            travel_complete_flag <= 1'b0;
        end
        else
        begin
            in_position_flag <= inp_now;
            rough_match_flag <= (remaining <= crp_range_r) & ~seq_running;
            travel_complete_flag <= inp_now & (remaining == '0) & ~seq_running;
        end
    end

    // Read mux
    wire [31:0] status_word = {25'h0, motor_stopped, servo_on, seg_relative,
        state_r != PTS_IDLE, travel_complete_flag, rough_match_flag, in_position_flag};
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            wb_dat_o <= 32'h0000_0000;
        end
        else if (bus_req && !wb_we_i)
        begin
            case (wb_adr_i)
                PTS_A_CTRL: wb_dat_o <= 32'(ctrl_nsp_r) << PTS_CTRL_NEW_SETPOINT;
                PTS_A_START: wb_dat_o <= {24'h0, start_sel_r};
                PTS_A_INP_RANGE: wb_dat_o <= inp_range_r;
                PTS_A_CRP_RANGE: wb_dat_o <= crp_range_r;
                PTS_A_STATUS: wb_dat_o <= status_word;
                PTS_A_CUR: wb_dat_o <= {16'h0, mcode_actual, point_actual};
                PTS_A_TBL_IDX: wb_dat_o <= {24'h0, tbl_idx_r};
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    assign wb_ack_o = ack_r;
endmodule : pts_sequencer

// File: tb/pts_prof_model.sv
`timescale 1ns/1ps
module pts_prof_model
    import pts_pkg::*;
#(
    parameter int SEG_LEN = 12
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Segment handshake
    input wire logic seg_load,
    output logic seg_near_end,
    output logic seg_done,
    output logic [PTS_POS_W-1:0] remaining
);
    logic [7:0] cnt_r;
    assign remaining = PTS_POS_W'(cnt_r);
    // Early warning well ahead of the end, so a blend never gaps
    assign seg_near_end = (cnt_r != 8'h00) && (cnt_r <= 8'h04);
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            cnt_r <= 8'h00;
            seg_done <= 1'b0;
        end
        else
        begin
            seg_done <= (cnt_r == 8'h01) && !seg_load;
            cnt_r <= seg_load ? 8'(SEG_LEN) : (cnt_r != 8'h00) ? cnt_r - 8'h01 : cnt_r;
        end
    end
endmodule : pts_prof_model

// File: tb/pts_sequencer_asserts.sv
`timescale 1ns/1ps
module pts_sequencer_chk
    import pts_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_ack_o,
    // Motion and status
    input wire logic [PTS_POS_W-1:0] droop,
    input wire logic [PTS_POS_W-1:0] remaining,
    input wire logic seg_near_end,
    input wire logic seg_done,
    input wire logic seg_load,
    input wire logic seg_blend,
    input wire logic in_position_flag,
    input wire logic rough_match_flag,
    input wire logic travel_complete_flag,
    input wire logic [PTS_IDX_W-1:0] point_actual
);
    logic [31:0] inp_r;
    logic [31:0] crp_r;
    wire wr_ok = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && (wb_sel_i == 4'hF);
    wire wr_inp = wr_ok && (wb_adr_i == PTS_A_INP_RANGE);
    wire wr_crp = wr_ok && (wb_adr_i == PTS_A_CRP_RANGE);
    // Flags lag the range shadows by a cycle; in-position and rough match judged only on a quiet bus
    wire quiet = !wb_cyc_i;
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            inp_r <= PTS_INP_RANGE_RST;
            crp_r <= PTS_CRP_RANGE_RST;
        end
        else
        begin
            inp_r <= wr_inp ? wb_dat_i : inp_r;
            crp_r <= wr_crp ? wb_dat_i : crp_r;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered");
    a_inp_match: assert property (
        $past(rst_b) && $past(quiet) && $past(quiet, 2)
        |-> in_position_flag == ($past(droop) <= inp_r)) else $error("in-position wrong");
    a_rough_range: assert property (
        $past(rst_b) && $past(quiet) && rough_match_flag |-> $past(remaining) <= crp_r)
        else $error("rough match outside range");
    a_travel_done: assert property (
        travel_complete_flag |-> in_position_flag && $past(remaining) == 0)
        else $error("travel complete too early");
    a_point_hold: assert property (
        !$stable(point_actual) |-> $past(seg_done) || $past(seg_done, 2))
        else $error("point changed mid-run");
    a_blend_near: assert property (
        seg_load && seg_blend |-> $past(seg_near_end, 2)) else $error("blend without near end");
    a_load_pulse: assert property (seg_load |=> !seg_load)
        else $error("load not a pulse");
    c_blend: cover property (seg_load && seg_blend);
    c_travel: cover property ($rose(travel_complete_flag));
    c_rough: cover property ($rose(rough_match_flag));
endmodule : pts_sequencer_chk
bind pts_sequencer pts_sequencer_chk chk_u (.clk(clk), .rst_b(rst_b),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_ack_o(wb_ack_o), .droop(droop),
    .remaining(remaining), .seg_near_end(seg_near_end), .seg_done(seg_done),
    .seg_load(seg_load), .seg_blend(seg_blend), .in_position_flag(in_position_flag),
    .rough_match_flag(rough_match_flag), .travel_complete_flag(travel_complete_flag),
    .point_actual(point_actual));

// File: tb/pts_sequencer_bench.sv
`timescale 1ns/1ps
module pts_sequencer_bench
    import pts_pkg::*;
;
    logic clk, rst_b, wb_req, wb_we, wb_ack_o, servo_on, motor_stopped;
    logic seg_near_end, seg_done, seg_load, seg_rel, seg_blend, inp_f, crp_f, mend_f;
    logic [7:0] wb_adr, point_actual, mcode_actual;
    logic [3:0] wb_sel, sel_v;
    logic [31:0] wb_wd, wb_dat_o, droop, remaining, seg_target, seed, rd;
    logic [15:0] seg_speed, seg_acc, seg_dec;
    logic [31:0] t_pos [256];
    logic [15:0] t_spd [256], t_acc [256], t_dec [256];
    logic [3:0] t_aux [256];
    logic [7:0] t_mc [256];
    logic [8:0] exp_q [$];
    logic [8:0] e;
    logic [3:0] codes [6] = '{4'h0, 4'h2, 4'h8, 4'h9, 4'hA, 4'hB};
    int n_errors = 0, check_count = 0, cyc_cnt = 0, n_loads = 0;
    pts_sequencer #(.DWELL_MS_CYCLES(4)) dut_u (.clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_req),
        .wb_stb_i(wb_req), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_wd),
        .wb_sel_i(wb_sel), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .servo_on(servo_on),
        .motor_stopped(motor_stopped), .droop(droop), .remaining(remaining),
        .seg_near_end(seg_near_end), .seg_done(seg_done), .seg_load(seg_load),
        .seg_target(seg_target), .seg_relative(seg_rel), .seg_blend(seg_blend),
        .seg_speed(seg_speed), .seg_acc(seg_acc), .seg_dec(seg_dec),
        .in_position_flag(inp_f), .rough_match_flag(crp_f), .travel_complete_flag(mend_f),
        .point_actual(point_actual), .mcode_actual(mcode_actual));
    pts_prof_model #(.SEG_LEN(12)) prof_u (.clk(clk), .rst_b(rst_b), .seg_load(seg_load),
        .seg_near_end(seg_near_end), .seg_done(seg_done), .remaining(remaining));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        check_count++;
        if (got !== ex)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    task automatic end_sim();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        wb_req <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_wd <= wd;
        wb_sel <= sel_v;
        do
            @(posedge clk);
        while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_req <= 1'b0;
    endtask : wb
    task automatic put(input logic [7:0] i, input logic [3:0] aux);
        logic [31:0] d;
        d = xs();
        t_pos[i] = xs();
        t_spd[i] = d[15:0];
        t_acc[i] = d[31:16];
        d = xs();
        t_dec[i] = d[15:0];
        t_mc[i] = d[23:16];
        t_aux[i] = aux;
        wb(1'b1, PTS_A_TBL_IDX, 32'(i));
        wb(1'b1, 8'h20, t_pos[i]);
        wb(1'b1, 8'h24, {t_acc[i], t_spd[i]});
        wb(1'b1, 8'h28, {16'h0000, t_dec[i]});
        wb(1'b1, 8'h2C, {20'h0_0000, t_mc[i], aux});
        wb(1'b1, 8'h30, 32'h0000_0000);
    endtask : put
    task automatic start(input logic [7:0] s);
        wb(1'b1, PTS_A_START, 32'(s));
        wb(1'b1, PTS_A_CTRL, 32'h0000_0010);
        wb(1'b1, PTS_A_CTRL, 32'h0000_0000);
    endtask : start
    task automatic run(input logic [7:0] s, input int n, input logic [3:0] code);
        logic [31:0] d;
        for (int j = 0; j < n - 1; j++)
        begin
            d = xs();
            // One entry per step, closed by the last code
            put(s + 8'(j), d[0] ? PTS_AUX_REL_CONT : PTS_AUX_ABS_CONT);
        end
        put(s + 8'(n - 1), code);
        for (int j = 0; j < n; j++)
            exp_q.push_back({j != 0, s + 8'(j)});
        if (code[3])
            exp_q.push_back({1'b0, code[0] ? PTS_FIRST_ENTRY : s});
        start(s);
        for (int k = 0; k < 9000 && exp_q.size() != 0; k++)
            @(posedge clk);
    endtask : run
    task automatic fin(input logic [7:0] p);
        for (int k = 0; k < 200 && seg_done !== 1'b1; k++)
            @(posedge clk);
        repeat (3) @(posedge clk);
        chk("point", 32'(p), 32'(point_actual));
        chk("mcode", 32'(t_mc[p]), 32'(mcode_actual));
        chk("travel", 32'h1, 32'(mend_f));
        chk("rough", 32'h1, 32'(crp_f));
        wb(1'b0, PTS_A_CUR, 32'h0000_0000);
        chk("cur reg", {16'h0000, t_mc[p], p}, rd);
    endtask : fin
    always @(posedge clk)
    begin
        cyc_cnt++;
        if (cyc_cnt == 40000)
        begin
            n_errors++;
            end_sim();
        end
    end
    always @(posedge clk)
    begin
        if (rst_b === 1'b1 && seg_load === 1'b1)
        begin
            n_loads++;
            chk("load wanted", 32'h1, 32'(exp_q.size() != 0));
            if (exp_q.size() != 0)
            begin
                e = exp_q.pop_front();
                chk("target", t_pos[e[7:0]], seg_target);
                chk("relative", 32'(t_aux[e[7:0]][1]), 32'(seg_rel));
                chk("blend", 32'(e[8]), 32'(seg_blend));
                chk("speed", 32'(t_spd[e[7:0]]), 32'(seg_speed));
                chk("acc", 32'(t_acc[e[7:0]]), 32'(seg_acc));
                chk("dec", 32'(t_dec[e[7:0]]), 32'(seg_dec));
            end
        end
    end
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial
    begin
        seed = 32'h0000_0046;
        {rst_b, wb_req, wb_we, wb_adr, wb_wd, droop} = '0;
        {servo_on, motor_stopped, sel_v, wb_sel} = {2'b11, 8'hFF};
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        wb(1'b0, PTS_A_INP_RANGE, 32'h0000_0000);
        chk("inp range", PTS_INP_RANGE_RST, rd);
        wb(1'b0, PTS_A_CRP_RANGE, 32'h0000_0000);
        chk("crp range", PTS_CRP_RANGE_RST, rd);
        wb(1'b0, 8'h3C, 32'h0000_0000);
        chk("unmapped", 32'h0000_0000, rd);
        sel_v = 4'h3;
        wb(1'b1, PTS_A_INP_RANGE, 32'h0000_0005);
        sel_v = 4'hF;
        wb(1'b0, PTS_A_INP_RANGE, 32'h0000_0000);
        chk("part write", PTS_INP_RANGE_RST, rd);
        wb(1'b1, PTS_A_CRP_RANGE, 32'h0000_0003);
        put(PTS_FIRST_ENTRY, PTS_AUX_ABS_END);
        foreach (codes[k])
        begin
            run(8'h10 + 8'(k * 4), 2 + k % 2, codes[k]);
            if (!codes[k][3])
                fin(8'h11 + 8'(k * 4 + k % 2));
            servo_on <= 1'b0;
            repeat (16) @(posedge clk);
            servo_on <= 1'b1;
        end
        motor_stopped <= 1'b0;
        e = 9'(n_loads);
        start(PTS_FIRST_ENTRY);
        repeat (30) @(posedge clk);
        chk("ignored start", 32'(e), 32'(n_loads));
        motor_stopped <= 1'b1;
        droop <= xs() | 32'h8000_0000;
        repeat (3) @(posedge clk);
        chk("inp far", 32'h0, 32'(inp_f));
        chk("travel far", 32'h0, 32'(mend_f));
        droop <= PTS_INP_RANGE_RST;
        repeat (3) @(posedge clk);
        chk("inp edge", 32'h1, 32'(inp_f));
        run(PTS_FIRST_ENTRY, 255, PTS_AUX_ABS_END);
        fin(8'hFF);
        end_sim();
    end
endmodule : pts_sequencer_bench
